/* serial_pixel_link_receiver_tb.sv */
// Purpose: self-checking bench for the pixel link receiver
// Assumes: detector inputs driven as levels; transmitter model on the lanes
// Notes: outputs are snapped on the falling edge to avoid edge races
`timescale 1ns/10ps
module serial_pixel_link_receiver_tb
  import splr_pkg::*;
;
  logic clk = 0, reset = 1, receiver_enable_pin = 0, clock_common_mode_level = 1;
  logic clock_rate_below_500k = 0, clock_rate_above_3m = 0, pll_locked = 0;
  logic bit_strobe, serial_lane_zero, serial_lane_one, busy, start = 0, corrupt = 0, bad;
  logic [1:0] rsv = 0, s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, vertical_sync_out, horizontal_sync_out, display_valid_out;
  logic pixel_clock_out, pll_enable, deserializer_enable, s_pclk, s_pll, s_des;
  logic [23:0] color_out;
  splr_pixel_t pay = '0, last_good, s_pix;
  int fail_count = 0, check_count = 0, errs = 0;

  splr_receiver dut (.clk, .reset, .receiver_enable_pin, .clock_common_mode_level,
    .clock_rate_below_500k, .clock_rate_above_3m, .pll_locked, .bit_strobe,
    .serial_lane_zero, .serial_lane_one, .color_out, .vertical_sync_out,
    .horizontal_sync_out, .display_valid_out, .pixel_clock_out, .pll_enable,
    .deserializer_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  splr_tx_model tx (.clk, .reset, .start, .payload(pay), .rsv, .corrupt, .busy,
    .bit_strobe, .lane0(serial_lane_zero), .lane1(serial_lane_one));

  always #20 clk = ~clk;
  always @(negedge clk)
    {s_pix, s_pclk, s_pll, s_des} <= {display_valid_out, horizontal_sync_out,
      vertical_sync_out, color_out, pixel_clock_out, pll_enable, deserializer_enable};

  task automatic chk(input logic [33:0] g, input logic [33:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
    end
    while (!b);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (r) s_axi_rready <= 1'h0;
    end
    while (!r);
  endtask
  task automatic mode_is(input logic [1:0] m);
    rd_reg(ADDR_STATUS);
    chk(rd[1:0], m, "mode");
  endtask
  task automatic send(input logic b);
    @(posedge clk);
    {pay, corrupt, rsv, start} <= {splr_pixel_t'(27'($urandom)), b, 2'($urandom), 1'h1};
    @(posedge clk);
    start <= 1'h0;
    do @(negedge clk); while (busy);
    @(negedge clk);
    @(posedge clk);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  initial
  begin
    #(40 * 20000);
    fail_count++;
    tally_and_finish;
  end

  initial
  begin
    void'($urandom(13));
    cyc(3);
    reset <= 1'h0;
    cyc(2);
    chk(s_pix, STATIC_PIXEL, "static");
    chk(s_pll, 1'h0, "pll");
    mode_is(SPLR_SHUTDOWN);
    rd_reg(ADDR_CTRL);
    chk(rd, 32'h1, "ctrl");
    rd_reg(8'h0C);
    chk({rr, rd}, {RESP_SLVERR, 32'h0}, "unmapped");
    done("reset");
    receiver_enable_pin <= 1'h1;
    cyc(100);
    receiver_enable_pin <= 1'h0;
    cyc(300);
    mode_is(SPLR_SHUTDOWN);
    chk(rd[3], 1'h0, "filtered enable");
    done("glitch");
    receiver_enable_pin <= 1'h1;
    cyc(260);
    mode_is(SPLR_STANDBY);
    chk(s_pll, 1'h0, "pll");
    {clock_common_mode_level, clock_rate_above_3m} <= 2'h1;
    cyc(6);
    mode_is(SPLR_ACQUIRE);
    chk(s_pll, 1'h1, "pll");
    send(1'h0);
    chk(s_pix, STATIC_PIXEL, "lanes ignored");
    clock_rate_below_500k <= 1'h1;
    cyc(6);
    mode_is(SPLR_STANDBY);
    chk(s_pll, 1'h0, "pll");
    clock_rate_below_500k <= 1'h0;
    cyc(6);
    mode_is(SPLR_ACQUIRE);
    done("modes");
    pll_locked <= 1'h1;
    cyc(6);
    chk(s_des, 1'h1, "deser");
    last_good = STATIC_PIXEL;
    for (int i = 0; i < 12; i++)
    begin
      bad = (i % 4 == 3) || ($urandom_range(0, 4) == 0);
      send(bad);
      if (bad) errs++;
      else last_good = pay;
      chk(s_pix, last_good, "pixel");
      chk(s_pclk, 1'h1, "pclk");
    end
    rd_reg(ADDR_PERR);
    chk(rd, 32'(errs), "perr");
    wr(ADDR_PERR, 32'h0);
    chk(rr, RESP_OKAY, "perr wr resp");
    rd_reg(ADDR_PERR);
    chk({rr, rd}, {RESP_OKAY, 32'h0}, "perr clear");
    wr(ADDR_CTRL, 32'h0);
    chk(rr, RESP_OKAY, "ctrl wr resp");
    send(1'h1);
    chk(s_pix, last_good, "pixel");
    rd_reg(ADDR_PERR);
    chk(rd, 32'h0, "perr off");
    wr(8'h0C, 32'h0);
    chk(rr, RESP_SLVERR, "unmapped wr");
    done("receive");
    pll_locked <= 1'h0;
    cyc(6);
    chk(s_des, 1'h0, "deser");
    chk(s_pix, STATIC_PIXEL, "static");
    mode_is(SPLR_ACQUIRE);
    clock_common_mode_level <= 1'h1;
    cyc(6);
    mode_is(SPLR_STANDBY);
    chk(s_pll, 1'h0, "pll");
    chk(s_pclk, 1'h0, "pclk");
    receiver_enable_pin <= 1'h0;
    cyc(260);
    mode_is(SPLR_SHUTDOWN);
    chk(s_pix, STATIC_PIXEL, "static");
    done("exit");
    tally_and_finish;
  end
endmodule // serial_pixel_link_receiver_tb

/* splr_pkg.sv */
// Purpose: shared constants and types for the serial pixel link receiver
// Assumes: 25 MHz system clock; bit-rate strobe supplied by the PLL wrapper
// Notes: frame bit mapping is held here so both link ends can share it
package splr_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int EN_HOLD_NS = 10000;
  localparam int EN_GLITCH_NS = 5000;
  localparam int EN_HOLD_CYC = (EN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EN_GLITCH_CYC = EN_GLITCH_NS / CLK_PERIOD_NS;
  localparam logic [8:0] EN_HOLD_CNT = 9'(EN_HOLD_CYC);

  localparam int BITS_PER_LANE = 15;
  localparam logic [3:0] BIT_CNT_LAST = 4'(BITS_PER_LANE - 1);
  localparam logic [3:0] PCLK_HIGH_BITS = 4'h7;

  // frame = {lane one word, lane zero word}, first bit in the msb of each
  localparam int FRAME_BITS = 2 * BITS_PER_LANE;
  localparam int PAYLOAD_LSB = 0;
  localparam int PAYLOAD_BITS = 27;
  localparam int PARITY_POS = 27;
  localparam int RSV0_POS = 28;
  localparam int RSV1_POS = 29;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PERR = 8'h08;
  localparam logic CTRL_COUNT_EN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SPLR_SHUTDOWN = 2'b00,
    SPLR_STANDBY = 2'b01,
    SPLR_ACQUIRE = 2'b10,
    SPLR_RECEIVE = 2'b11
  } splr_mode_t;

  typedef struct packed {
    logic valid;
    logic hsync;
    logic vsync;
    logic [23:0] color;
  } splr_pixel_t;

  localparam splr_pixel_t STATIC_PIXEL = '{valid: 1'b0, hsync: 1'b1, vsync: 1'b1,
                                           color: 24'hFFFFFF};

  typedef struct packed {
    splr_mode_t mode;
    logic en_filt;
    logic [8:0] en_cnt;
    logic cm_s1;
    logic cm_s2;
    logic slow_s1;
    logic slow_s2;
    logic act_s1;
    logic act_s2;
    logic lock_s1;
    logic lock_s2;
    logic lock_seen;
    logic pll_en;
    logic deser_en;
    logic [14:0] sh0;
    logic [14:0] sh1;
    logic [3:0] bit_cnt;
    splr_pixel_t pix;
    splr_pixel_t last_good;
    logic pclk;
    logic count_en;
    logic [15:0] perr_cnt;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } splr_state_t;

endpackage

/* splr_receiver.sv */
// Purpose: mode sequencer, deserializer and parity screen of the pixel link receiver
// Assumes: all inputs synchronous to clk; bit_strobe pulses once per link bit period
// Notes:
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
module splr_receiver
  import splr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic receiver_enable_pin,
  input wire logic clock_common_mode_level,
  input wire logic clock_rate_below_500k,
  input wire logic clock_rate_above_3m,
  input wire logic pll_locked,
  input wire logic bit_strobe,
  input wire logic serial_lane_zero,
  input wire logic serial_lane_one,
  output logic [23:0] color_out,
  output logic vertical_sync_out,
  output logic horizontal_sync_out,
  output logic display_valid_out,
  output logic pixel_clock_out,
  output logic pll_enable,
  output logic deserializer_enable,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  splr_state_t s_r;
  splr_state_t s_nxt;
  logic frame_done;
  logic [FRAME_BITS-1:0] frame;
  splr_pixel_t rx_pixel;
  logic rx_parity;
  logic parity_ok;
  logic clock_bad;

  // slot mapping is the only place that knows where payload and parity sit
  // built from the registered shifters and the incoming bits, so no loop through s_nxt
  assign frame = {s_r.sh1[13:0], serial_lane_one, s_r.sh0[13:0], serial_lane_zero};
  assign rx_pixel = splr_pixel_t'(frame[PAYLOAD_LSB +: PAYLOAD_BITS]);
  assign rx_parity = frame[PARITY_POS];
  assign parity_ok = ^{rx_pixel, rx_parity};
  assign clock_bad = s_r.cm_s2 || s_r.slow_s2;

  always_comb
  begin
    s_nxt = s_r;
    frame_done = 1'b0;
    // detector levels pass two flops before anything looks at them
    s_nxt.cm_s1 = clock_common_mode_level;
    s_nxt.cm_s2 = s_r.cm_s1;
    s_nxt.slow_s1 = clock_rate_below_500k;
    s_nxt.slow_s2 = s_r.slow_s1;
    s_nxt.act_s1 = clock_rate_above_3m;
    s_nxt.act_s2 = s_r.act_s1;
    s_nxt.lock_s1 = pll_locked;
    s_nxt.lock_s2 = s_r.lock_s1;

    // enable filter: the pin must differ from the filtered level a full hold time
    if (receiver_enable_pin == s_r.en_filt)
    begin
      s_nxt.en_cnt = 9'h000;
    end
    else if (s_r.en_cnt == EN_HOLD_CNT)
    begin
      s_nxt.en_filt = receiver_enable_pin;
      s_nxt.en_cnt = 9'h000;
    end
    else
    begin
      s_nxt.en_cnt = s_r.en_cnt + 9'h001;
    end

    case (s_r.mode)
      SPLR_SHUTDOWN:
      begin
        // pin and clock lane are still sensed here
        if (s_r.en_filt && s_r.cm_s2)
          s_nxt.mode = SPLR_STANDBY;
      end
      SPLR_STANDBY:
      begin
        if (!s_r.en_filt)
          s_nxt.mode = SPLR_SHUTDOWN;
        else if (!clock_bad && s_r.act_s2)
          s_nxt.mode = SPLR_ACQUIRE;
      end
      SPLR_ACQUIRE:
      begin
        if (!s_r.en_filt)
          s_nxt.mode = SPLR_SHUTDOWN;
        else if (clock_bad)
          s_nxt.mode = SPLR_STANDBY;
        else if (s_r.lock_s2)
          s_nxt.mode = SPLR_RECEIVE;
      end
      SPLR_RECEIVE:
      begin
        if (!s_r.en_filt)
          s_nxt.mode = SPLR_SHUTDOWN;
        else if (clock_bad)
          s_nxt.mode = SPLR_STANDBY;
        else if (!s_r.lock_s2)
          s_nxt.mode = SPLR_ACQUIRE;
      end
      default:
      begin
        s_nxt.mode = SPLR_SHUTDOWN;
      end
    endcase

    if (s_nxt.mode == SPLR_SHUTDOWN || s_nxt.mode == SPLR_STANDBY)
      s_nxt.lock_seen = 1'b0;
    else if (s_nxt.mode == SPLR_RECEIVE)
      s_nxt.lock_seen = 1'b1;

    s_nxt.pll_en = (s_nxt.mode == SPLR_ACQUIRE) || (s_nxt.mode == SPLR_RECEIVE);
    s_nxt.deser_en = (s_nxt.mode == SPLR_RECEIVE);

    if (s_nxt.mode != SPLR_RECEIVE)
    begin
      // lanes ignored and bus parked until lock is reached
      s_nxt.bit_cnt = 4'h0;
      s_nxt.pclk = 1'b0;
      s_nxt.pix = STATIC_PIXEL;
    end
    else if (bit_strobe)
    begin
      s_nxt.sh0 = {s_r.sh0[13:0], serial_lane_zero};
      s_nxt.sh1 = {s_r.sh1[13:0], serial_lane_one};
      if (s_r.bit_cnt == BIT_CNT_LAST)
      begin
        s_nxt.bit_cnt = 4'h0;
        frame_done = 1'b1;
      end
      else
      begin
        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
      end
      s_nxt.pclk = (s_nxt.bit_cnt < PCLK_HIGH_BITS);
    end

    // judged only in receive, i.e. after clock detect and lock
    if (frame_done && s_r.lock_seen)
    begin
      if (parity_ok)
      begin
        s_nxt.pix = rx_pixel;
        s_nxt.last_good = rx_pixel;
      end
      else
      begin
        // a bad word must not disturb the syncs, so replay the last good one
        s_nxt.pix = s_r.last_good;
      end
    end

    // register bus: address and data may arrive in either order
    if (s_r.awready && s_axi_awvalid)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_r.wready && s_axi_wvalid)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;

    if (frame_done && s_r.lock_seen && !parity_ok && s_r.count_en)
      s_nxt.perr_cnt = s_r.perr_cnt + 16'h0001;

    if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      if (s_r.awaddr == ADDR_CTRL)
      begin
        if (s_r.wstrb[0])
          s_nxt.count_en = s_r.wdata[0];
      end
      else if (s_r.awaddr == ADDR_PERR)
      begin
        // an error landing in the clearing cycle is still counted
        s_nxt.perr_cnt = (frame_done && s_r.lock_seen && !parity_ok && s_r.count_en)
                         ? 16'h0001 : 16'h0000;
      end
      else if (s_r.awaddr != ADDR_STATUS)
      begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_r.arready && s_axi_arvalid)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL)
        s_nxt.rdata = {31'h00000000, s_r.count_en};
      else if (s_axi_araddr == ADDR_STATUS)
        s_nxt.rdata = {26'h0000000, s_r.lock_seen, s_r.lock_s2, s_r.en_filt,
                       s_r.pll_en, s_r.mode};
      else if (s_axi_araddr == ADDR_PERR)
        s_nxt.rdata = {16'h0000, s_r.perr_cnt};
      else
      begin
        s_nxt.rdata = 32'h00000000;
        s_nxt.rresp = RESP_SLVERR;
      end
    end
    s_nxt.arready = !s_nxt.rvalid;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.pix <= STATIC_PIXEL;
      s_r.last_good <= STATIC_PIXEL;
      s_r.count_en <= CTRL_COUNT_EN_RESET;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign color_out = s_r.pix.color;
  assign vertical_sync_out = s_r.pix.vsync;
  assign horizontal_sync_out = s_r.pix.hsync;
  assign display_valid_out = s_r.pix.valid;
  assign pixel_clock_out = s_r.pclk;
  assign pll_enable = s_r.pll_en;
  assign deserializer_enable = s_r.deser_en;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_standby_static_bus: assert property (
    s_r.mode == SPLR_STANDBY |-> s_r.pix == STATIC_PIXEL && !s_r.pclk)
    else $error("standby output not static");
  a_acquire_static_bus: assert property (
    s_r.mode == SPLR_ACQUIRE |-> s_r.pix == STATIC_PIXEL && !s_r.pclk && s_r.pll_en)
    else $error("acquire output not static or pll off");
  a_shutdown_all_off: assert property (
    s_r.mode == SPLR_SHUTDOWN |-> !s_r.pll_en && !s_r.deser_en && s_r.pix == STATIC_PIXEL)
    else $error("shutdown left logic running");
  a_standby_pll_off: assert property (
    s_r.mode == SPLR_STANDBY |-> !s_r.pll_en && !s_r.lock_seen)
    else $error("pll on in standby");
  a_common_mode_sleep: assert property (
    s_r.mode inside {SPLR_ACQUIRE, SPLR_RECEIVE} && s_r.en_filt && s_r.cm_s2
    |=> s_r.mode == SPLR_STANDBY)
    else $error("high common mode did not force standby");
  a_slow_clock_sleep: assert property (
    s_r.mode inside {SPLR_ACQUIRE, SPLR_RECEIVE} && s_r.en_filt && s_r.slow_s2
    |=> s_r.mode == SPLR_STANDBY)
    else $error("slow clock did not force standby");
  a_lock_to_receive: assert property (
    s_r.mode == SPLR_ACQUIRE && s_r.en_filt && !clock_bad && s_r.lock_s2
    |=> s_r.mode == SPLR_RECEIVE)
    else $error("lock did not enter receive");
  a_wake_needs_clock: assert property (
    $past(s_r.mode) == SPLR_STANDBY && s_r.mode == SPLR_ACQUIRE
    |-> $past(s_r.en_filt) && $past(s_r.act_s2) && !$past(clock_bad))
    else $error("woke without valid clock");
  a_parity_repeat_word: assert property (
    frame_done && s_r.lock_seen && !parity_ok |=> s_r.pix == $past(s_r.last_good))
    else $error("bad word not replaced");
  a_enable_filter_hold: assert property (
    $changed(s_r.en_filt) |-> $past(s_r.en_cnt) == EN_HOLD_CNT)
    else $error("enable level changed before hold time");

  c_enter_receive: cover property (s_r.mode == SPLR_ACQUIRE ##1 s_r.mode == SPLR_RECEIVE);
  c_parity_error: cover property (frame_done && s_r.lock_seen && !parity_ok);
  c_receive_to_standby: cover property (s_r.mode == SPLR_RECEIVE ##1 s_r.mode == SPLR_STANDBY);
  c_shutdown_entry: cover property (s_r.mode != SPLR_SHUTDOWN ##1 s_r.mode == SPLR_SHUTDOWN);

endmodule // splr_receiver

/* splr_tx_model.sv */
// Purpose: serializer transmitter model for the two data lanes
// Assumes: one lane bit per strobe, a strobe every second clock
// Notes: idle lanes toggle so a stale bit never looks like data
`timescale 1ns/10ps
module splr_tx_model
  import splr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire splr_pixel_t payload,
  input wire logic [1:0] rsv,
  input wire logic corrupt,
  output logic busy,
  output logic bit_strobe,
  output logic lane0,
  output logic lane1
);
  logic [14:0] sh0_r, sh1_r;
  logic [3:0] cnt_r;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      {busy, bit_strobe, lane0, lane1, sh0_r, sh1_r, cnt_r} <= '0;
    end
    else
    begin
      bit_strobe <= 1'h0;
      lane0 <= ~lane0;
      lane1 <= ~lane1;
      if (start && !busy)
      begin
        // odd parity over payload only; reserved bits random
        {sh1_r, sh0_r} <= {rsv, (~^payload) ^ corrupt, payload};
        cnt_r <= 4'h0;
        busy <= 1'h1;
      end
      else if (busy && !bit_strobe)
      begin
        // strobe rate stands for a link clock in range
        // msb first, 15 bits on each lane
        bit_strobe <= 1'h1;
        lane0 <= sh0_r[14];
        lane1 <= sh1_r[14];
        sh0_r <= sh0_r << 1;
        sh1_r <= sh1_r << 1;
        // count strobes: trailing zero bits must still be sent
        cnt_r <= cnt_r + 4'h1;
        busy <= (cnt_r != 4'hE);
      end
    end
  end
endmodule // splr_tx_model
